// [sdac_consts.svh]
// register map, field positions, reset values and timing counts of the converter control
`ifndef SDAC_CONSTS_SVH
`define SDAC_CONSTS_SVH

// register indices; byte address is four times the index
`define SDAC_IDX_DATA 16'h4900
`define SDAC_IDX_CFG 16'h4902
`define SDAC_IDX_INT_CFG 16'h461A
`define SDAC_IDX_INT_FLAG 16'h4616
`define SDAC_IDX_INT_MISS 16'h461C
`define SDAC_ADR_W 18

// configuration fields
`define SDAC_CFG_EN_BIT 0
`define SDAC_CFG_DITH_BIT 1
`define SDAC_CFG_SEL_LSB 8
`define SDAC_CFG_SEL_MSB 11
`define SDAC_CFG_RATE_LSB 12
`define SDAC_CFG_RATE_MSB 14
`define SDAC_CFG_RST 16'h0000
`define SDAC_DATA_RST 16'h0000

// converter bit in the top-level flag, mask and miss registers
`define SDAC_INT_BIT 11

// modulator sample period and conversion lengths
`define SDAC_CLK_PERIOD_NS 50
`define SDAC_MOD_PERIOD_NS 1000
`define SDAC_MOD_CYCLES (`SDAC_MOD_PERIOD_NS / `SDAC_CLK_PERIOD_NS)
`define SDAC_CONV_BASE_US 32
`define SDAC_MOD_RATE_MHZ 1
`define SDAC_CONV_BASE_SAMPLES (`SDAC_CONV_BASE_US * `SDAC_MOD_RATE_MHZ)
`define SDAC_TOP_BITS 5
`define SDAC_TOP_SHIFT 11

`endif

// [sdac_pkg.sv]
// types shared by the converter control files
`default_nettype none
package sdac_pkg;

  typedef logic [2:0] sdac_rate_t;
  typedef logic [3:0] sdac_sel_t;
  typedef logic [15:0] sdac_word_t;
  typedef logic [12:0] sdac_cnt_t;

  // analog source codes of the input selector
  typedef enum logic [3:0] {
    SDAC_SRC_PIN0 = 4'h0,
    SDAC_SRC_PIN1 = 4'h1,
    SDAC_SRC_PIN2 = 4'h2,
    SDAC_SRC_PIN3 = 4'h3,
    SDAC_SRC_PAD_SUPPLY_Q = 4'h4,
    SDAC_SRC_CORE_HALF = 4'h5,
    SDAC_SRC_RSVD = 4'h6,
    SDAC_SRC_GND = 4'h7,
    SDAC_SRC_VREF = 4'h8,
    SDAC_SRC_DIFF01 = 4'h9,
    SDAC_SRC_DIFF23 = 4'hA
  } sdac_src_e;

  localparam int SDAC_NUM_SRC = 11;

endpackage
`default_nettype wire

// [sdac_decim.sv]
// decimating counter filter: ones density of the modulator stream to a left-aligned sample
`timescale 1ns/1ps
`default_nettype none
`include "sdac_consts.svh"

module sdac_decim
  import sdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic stb_i,
  input wire logic bit_i,
  input wire sdac_rate_t rate_i,
  output logic done_o,
  output sdac_word_t result_o
);

  sdac_cnt_t smp_cnt_q;
  sdac_cnt_t ones_q;
  sdac_cnt_t nsamp;
  sdac_cnt_t total;
  sdac_cnt_t sat;
  logic [3:0] shamt;
  logic last;
  logic [15:0] wide;
  logic [12:0] gap_q;

  // conversion length doubles per rate code
  assign nsamp = 13'(`SDAC_CONV_BASE_SAMPLES) << rate_i;
  assign last = stb_i && (smp_cnt_q == nsamp - 13'd1);
  assign total = ones_q + {12'h000, bit_i};
  // a full-density run would overflow the field, so it saturates to all ones
  assign sat = (total >= nsamp) ? nsamp - 13'd1 : total;
  assign shamt = 4'(`SDAC_TOP_SHIFT) - {1'b0, rate_i};
  assign wide = {3'b000, sat};

  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush_i)
    begin
      smp_cnt_q <= 13'h0000;
      ones_q <= 13'h0000;
    end
    else if (last)
    begin
      smp_cnt_q <= 13'h0000;
      ones_q <= 13'h0000;
    end
    else if (stb_i)
    begin
      smp_cnt_q <= smp_cnt_q + 13'd1;
      ones_q <= total;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      result_o <= `SDAC_DATA_RST;
    end
    else
    begin
      done_o <= last && !flush_i;
      if (last && !flush_i)
      begin
        result_o <= wide << shamt;
      end
    end
  end

  // helper: strobes counted since the last completion or flush
  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush_i || done_o)
    begin
      gap_q <= 13'h0000;
    end
    else if (stb_i)
    begin
      gap_q <= gap_q + 13'd1;
    end
  end

  conv_length_a: assert property (@(posedge clk_i) disable iff (rst_i || flush_i)
    $rose(done_o) |-> gap_q == nsamp)
    else $error("conversion did not span the selected number of samples");

  done_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |=> !done_o)
    else $error("completion event lasted more than one cycle");

endmodule
`default_nettype wire

// [sdac_ctrl.sv]
// sigma-delta converter control: wishbone registers, modulator timing, source routing, interrupt
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "sdac_consts.svh"

module sdac_ctrl
  import sdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`SDAC_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // modulator and analog front end
  input wire logic mod_bit_i,
  output logic mod_stb_o,
  output logic mod_en_o,
  output logic dith_dis_o,
  output logic [SDAC_NUM_SRC-1:0] src_route_o,
  output logic vref_out_en_o,
  // interrupt to the processor
  output logic irq_o
);

  localparam int MOD_CYC = `SDAC_MOD_CYCLES;

  logic [15:0] cfg_q;
  logic [15:0] data_q;
  logic flag_q;
  logic mask_q;
  logic miss_q;
  logic [4:0] div_q;
  logic stb_tick;
  logic bit_s1_q;
  logic bit_s2_q;
  logic done_ev;
  sdac_word_t result;
  logic en;
  sdac_rate_t rate;
  sdac_sel_t src_sel;
  logic [15:0] widx;
  logic acc;
  logic wr;
  logic rd;
  logic lo_lane;
  logic hi_lane;
  logic [15:0] rdata;
  logic flag_clr;
  logic miss_clr;

  assign en = cfg_q[`SDAC_CFG_EN_BIT];
  assign rate = cfg_q[`SDAC_CFG_RATE_MSB:`SDAC_CFG_RATE_LSB];
  assign src_sel = cfg_q[`SDAC_CFG_SEL_MSB:`SDAC_CFG_SEL_LSB];

  // ---- wishbone decode
  assign widx = adr_i[17:2];
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr = acc && we_i;
  assign rd = acc && !we_i;
  assign lo_lane = sel_i[0];
  assign hi_lane = sel_i[1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= acc;
    end
  end

  // unmapped words answer with zero data and an ordinary ack
  always_comb
  begin
    rdata = 16'h0000;
    unique case (widx)
      `SDAC_IDX_DATA: rdata = data_q;
      `SDAC_IDX_CFG: rdata = cfg_q;
      `SDAC_IDX_INT_FLAG: rdata = 16'(flag_q) << `SDAC_INT_BIT;
      `SDAC_IDX_INT_CFG: rdata = 16'(mask_q) << `SDAC_INT_BIT;
      `SDAC_IDX_INT_MISS: rdata = 16'(miss_q) << `SDAC_INT_BIT;
      default: rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (rd)
    begin
      dat_o <= {16'h0000, rdata};
    end
  end

  // configuration; only the documented fields are writable, the rest read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= `SDAC_CFG_RST;
    end
    else if (wr && widx == `SDAC_IDX_CFG)
    begin
      if (lo_lane)
      begin
        cfg_q[`SDAC_CFG_EN_BIT] <= dat_i[`SDAC_CFG_EN_BIT];
        cfg_q[`SDAC_CFG_DITH_BIT] <= dat_i[`SDAC_CFG_DITH_BIT];
      end
      if (hi_lane)
      begin
        cfg_q[`SDAC_CFG_SEL_MSB:`SDAC_CFG_SEL_LSB] <= dat_i[`SDAC_CFG_SEL_MSB:`SDAC_CFG_SEL_LSB];
        cfg_q[`SDAC_CFG_RATE_MSB:`SDAC_CFG_RATE_LSB] <= dat_i[`SDAC_CFG_RATE_MSB:`SDAC_CFG_RATE_LSB];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= 1'b0;
    end
    else if (wr && widx == `SDAC_IDX_INT_CFG && hi_lane)
    begin
      mask_q <= dat_i[`SDAC_INT_BIT];
    end
  end

  // ---- modulator timing: the divider free-runs only while enabled so the first
  // sample comes a fixed time after enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en)
    begin
      div_q <= 5'd0;
    end
    else if (div_q == 5'(MOD_CYC - 1))
    begin
      div_q <= 5'd0;
    end
    else
    begin
      div_q <= div_q + 5'd1;
    end
  end

  assign stb_tick = en && (div_q == 5'(MOD_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mod_stb_o <= 1'b0;
    end
    else
    begin
      mod_stb_o <= stb_tick;
    end
  end

  // comparator output is asynchronous to clk_i
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_s1_q <= 1'b0;
      bit_s2_q <= 1'b0;
    end
    else
    begin
      bit_s1_q <= mod_bit_i;
      bit_s2_q <= bit_s1_q;
    end
  end

  // the filter is linear in ones density, so the offset input stage places ground
  // near one third and the reference near two thirds of full scale
  sdac_decim u_decim (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(!en),
    .stb_i(stb_tick),
    .bit_i(bit_s2_q),
    .rate_i(rate),
    .done_o(done_ev),
    .result_o(result)
  );

  // result register changes only on a completed conversion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_q <= `SDAC_DATA_RST;
    end
    else if (done_ev && en)
    begin
      data_q <= result;
    end
  end

  // ---- source routing, one select line per analog source
  genvar g;
  generate
    for (g = 0; g < SDAC_NUM_SRC; g++)
    begin : g_route
      assign src_route_o[g] = en && (src_sel == 4'(g)) && (4'(g) != SDAC_SRC_RSVD);
    end
  endgenerate

  assign mod_en_o = en;
  assign dith_dis_o = cfg_q[`SDAC_CFG_DITH_BIT];
  assign vref_out_en_o = en;

  // ---- interrupt flag: write one clears, a coincident event wins
  assign flag_clr = wr && widx == `SDAC_IDX_INT_FLAG && hi_lane && dat_i[`SDAC_INT_BIT];
  assign miss_clr = wr && widx == `SDAC_IDX_INT_MISS && hi_lane && dat_i[`SDAC_INT_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_q <= 1'b0;
    end
    else if (done_ev && en)
    begin
      flag_q <= 1'b1;
    end
    else if (flag_clr)
    begin
      flag_q <= 1'b0;
    end
  end

  // no queueing: an event on a still-pending flag is only recorded as missed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      miss_q <= 1'b0;
    end
    else if (done_ev && en && flag_q && !flag_clr)
    begin
      miss_q <= 1'b1;
    end
    else if (miss_clr)
    begin
      miss_q <= 1'b0;
    end
  end

  assign irq_o = flag_q && mask_q;

  // ---- checks
  mod_period_a: assert property (@(posedge clk_i) disable iff (rst_i || !en)
    stb_tick |-> ##20 stb_tick)
    else $error("modulator strobe not spaced at one microsecond");

  start_at_once_a: assert property (@(posedge clk_i) disable iff (rst_i || !en)
    $rose(en) |-> ##[1:20] stb_tick)
    else $error("no modulator sample soon after enable");

  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_ev && en) |=> flag_q)
    else $error("completion did not set the pending flag");

  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(irq_o) |-> (($rose(flag_q) && $past(done_ev)) || $rose(mask_q)))
    else $error("interrupt rose without a new event or a newly set mask");

  clear_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_clr && !(done_ev && en)) |=> !flag_q)
    else $error("write of one did not clear the pending flag");

  idle_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!en && !$past(en)) |-> ($stable(data_q) && !$rose(flag_q)))
    else $error("result or flag changed while disabled");

  vref_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vref_out_en_o == en)
    else $error("reference output not following enable");

  low_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_ev && en) |=> ((data_q & (16'hFFFF >> (5 + rate))) == 16'h0000))
    else $error("result has bits below the valid width");

  reserved_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_sel == SDAC_SRC_RSVD || src_sel > SDAC_SRC_DIFF23 || !en) |-> (src_route_o == '0))
    else $error("reserved or out-of-range source routed");

  back_to_back_a: assert property (@(posedge clk_i) disable iff (rst_i || !en)
    done_ev |-> ##[1:2] (u_decim.smp_cnt_q == 13'h0000))
    else $error("filter did not restart after a conversion");

endmodule
`default_nettype wire

// [sdac_mod_model.sv]
// behavioural modulator front end: first-order sigma-delta bit stream per selected source
`timescale 1ns/1ps
`default_nettype none

module sdac_mod_model
  import sdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic mod_stb_i,
  input wire logic mod_en_i,
  input wire logic [SDAC_NUM_SRC-1:0] src_route_i,
  input wire sdac_word_t pin_level_i,
  output logic mod_bit_o
);
  logic [16:0] acc_q = 17'h00000;
  sdac_word_t lvl;
  initial mod_bit_o = 1'b0;
  // ground and reference sit at one and two thirds, not at the rails
  always_comb
  begin
    lvl = pin_level_i;
    if (src_route_i[SDAC_SRC_GND])
      lvl = 16'h5200;
    if (src_route_i[SDAC_SRC_VREF])
      lvl = 16'hA800;
  end
  // idle comparator output wanders, so a stale bit never looks valid
  always @(posedge clk_i)
  begin
    if (!mod_en_i)
      mod_bit_o <= ~mod_bit_o;
    else if (mod_stb_i)
    begin
      acc_q <= {1'b0, acc_q[15:0]} + {1'b0, lvl};
      mod_bit_o <= acc_q[15:0] + lvl > 17'h0FFFF;
    end
  end
endmodule
`default_nettype wire

// [tb_sdac_ctrl.sv]
// self-checking testbench of the converter control
`timescale 1ns/1ps
`default_nettype none
`include "sdac_consts.svh"

module tb_sdac_ctrl
  import sdac_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [17:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dat_o;
  logic ack, mod_bit, mod_stb, mod_en, dith, vref_en, irq;
  logic [10:0] route;
  sdac_word_t lvl = 0, rnd = 16'h004A, r, d;
  int error_cnt = 0, checks = 0, cyc_n = 0, t1, t2, e;

  sdac_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .mod_bit_i(mod_bit), .mod_stb_o(mod_stb),
    .mod_en_o(mod_en), .dith_dis_o(dith), .src_route_o(route), .vref_out_en_o(vref_en), .irq_o(irq));
  sdac_mod_model model (.clk_i(clk_i), .mod_stb_i(mod_stb), .mod_en_i(mod_en), .src_route_i(route),
    .pin_level_i(lvl), .mod_bit_o(mod_bit));

  always #25 clk_i = ~clk_i;

  task automatic final_report;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // rough budget: four rates times three conversions plus the side scenarios
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic int exp_res(input int rt, input logic [15:0] l);
    int n, o;
    n = 32 << rt;
    o = (n * l) >> 16;
    if (o > n - 1)
      o = n - 1;
    return o << (11 - rt);
  endfunction

  // one classic cycle; the slave decides when ack comes
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= 4'h3;
    adr <= {idx, 2'b00};
    dat <= {16'h0000, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      check("ack", ack, 1'b1);
    r = dat_o[15:0];
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000)
      check("irq_wait", irq, 1'b1);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, `SDAC_IDX_CFG, 0);
    check("cfg_rst", r, `SDAC_CFG_RST);
    wb(0, `SDAC_IDX_DATA, 0);
    check("data_rst", r, `SDAC_DATA_RST);
    wb(1, `SDAC_IDX_CFG, 16'h0002);
    check("dither_on", dith, 1'b1);
    wb(1, `SDAC_IDX_CFG, 0);
    check("dither_off", dith, 1'b0);
    wb(1, 16'h1234, 16'hFFFF);
    wb(0, 16'h1234, 0);
    check("unmapped", r, 16'h0000);
    for (int c = 0; c < 16; c++)
    begin
      wb(1, `SDAC_IDX_CFG, 16'(c << 8) | 16'h0001);
      check("route", {5'h00, route}, (c <= 10 && c != 6) ? 16'(1 << c) : 16'h0000);
      check("vref_on", vref_en, 1'b1);
      check("mod_en", mod_en, 1'b1);
      wb(1, `SDAC_IDX_CFG, 0);
      check("vref_off", vref_en, 1'b0);
    end
    wb(1, `SDAC_IDX_INT_CFG, 16'h0800);
    for (int rt = 0; rt < 4; rt++)
    begin
      rnd = lfsr(rnd);
      lvl <= rnd;
      wb(1, `SDAC_IDX_CFG, {1'b0, 3'(rt), (rt == 0) ? 4'h7 : (rt == 1) ? 4'h8 : {2'b00, rnd[1:0]}, 8'h01});
      while (mod_stb !== 1'b1) @(posedge clk_i);
      t1 = cyc_n;
      @(posedge clk_i);
      while (mod_stb !== 1'b1) @(posedge clk_i);
      check("stb_gap", 16'(cyc_n - t1), 16'd20);
      // first result after enable is stale and thrown away
      wait_irq();
      wb(1, `SDAC_IDX_INT_FLAG, 16'h0800);
      check("irq_clr", irq, 1'b0);
      wait_irq();
      t1 = cyc_n;
      wb(0, `SDAC_IDX_DATA, 0);
      d = r;
      e = exp_res(rt, (rt == 0) ? 16'h5200 : (rt == 1) ? 16'hA800 : rnd);
      check("res_near", ((d > e) ? d - e : e - d) <= (2 << (11 - rt)), 1'b1);
      check("res_low", d & 16'((1 << (11 - rt)) - 1), 16'h0000);
      wb(1, `SDAC_IDX_INT_FLAG, 16'h0800);
      wait_irq();
      t2 = cyc_n;
      check("period", 16'(t2 - t1), 16'(20 * (32 << rt)));
      wb(1, `SDAC_IDX_CFG, 0);
      wb(1, `SDAC_IDX_INT_FLAG, 16'h0800);
    end
    wb(1, `SDAC_IDX_INT_CFG, 0);
    wb(1, `SDAC_IDX_CFG, 16'h0701);
    // two whole conversions at rate 0 by the 642-cycle walk
    repeat (2 * 642) @(posedge clk_i);
    wb(0, `SDAC_IDX_INT_FLAG, 0);
    check("flag_set", r & 16'h0800, 16'h0800);
    check("masked", irq, 1'b0);
    wb(1, `SDAC_IDX_INT_CFG, 16'h0800);
    check("unmasked", irq, 1'b1);
    // two completions with the flag still pending record a missed event
    wb(0, `SDAC_IDX_INT_MISS, 0);
    check("miss_set", r & 16'h0800, 16'h0800);
    wb(1, `SDAC_IDX_INT_MISS, 16'h0800);
    wb(0, `SDAC_IDX_INT_MISS, 0);
    check("miss_clr", r, 16'h0000);
    wb(1, `SDAC_IDX_CFG, 0);
    wb(0, `SDAC_IDX_DATA, 0);
    d = r;
    wb(1, `SDAC_IDX_INT_FLAG, 16'h0800);
    check("w1c", irq, 1'b0);
    repeat (2 * 642) @(posedge clk_i);
    check("idle_irq", irq, 1'b0);
    wb(0, `SDAC_IDX_DATA, 0);
    check("idle_data", r, d);
    final_report();
  end
endmodule
`default_nettype wire
